// ===== hdl/scr_pkg.sv
// Functional notes
// - Fetch counter is 12 bits and addresses a 4 Kbyte program space.
// - Lowest 512 program bytes are the zero page for vectors and short calls.
// - Data RAM holds 256 nibbles, reachable through four 8-bit pointers.
// - Operations use stack top and second item and return results to the stack.
// - Return stack entries are 12 bits and hold call and interrupt return addresses.
// - Fetch counter steps by one on a sequence op or a set step bit, or loads a branch/call/return target.
// - Table instruction reads an 8-bit constant at the fetch counter.
// - Expression pointer marks second item, pre-increments on push, post-decrements on pop.
// - Pop copies second item into stack top before the pointer decrements.
// - Return pointer moves by 4; each 12-bit push leaves one nibble unwritten.
// - General pointer fetch pushes the nibble, store writes stack top; pre-inc and post-dec.
// - Stack top takes data from ALU, program memory, data RAM or I/O bus.
// - Flag register is 4 bits holding branch, carry and interrupt enable.
// - ALU and preset, toggle, write and mask instructions change the flags.
// - Carry records arithmetic carry or borrow and acts as fifth bit in shifts.
// - Boolean logic operations leave the carry flag unchanged.
// - Conditional branch jumps only on branch flag; ALU classes all update it.
// - Reset and mask instruction clear interrupt enable; clear enable blocks interrupts.
// - Interrupt enable is set only by the unmask or sleep instructions.
// - A machine cycle is two clocks; every instruction commits in one of them.
package scr_pkg;
  localparam int FC_W         = 12;
  localparam int PTR_W        = 8;
  localparam int NIB_W        = 4;
  localparam int RAM_WORDS    = 256;
  localparam int RS_NIBS      = 3;
  localparam int ZP_W         = 9;
  localparam int MCYCLE_CLKS  = 2;
  localparam int CLK_PERIOD_NS = 20;

  localparam logic [FC_W-1:0]  ZP_LIMIT   = 12'h200;
  localparam logic [FC_W-1:0]  FC_RESET   = 12'h000;
  localparam logic [FC_W-1:0]  FC_STEP    = 12'h001;
  localparam logic [PTR_W-1:0] PTR_RESET  = 8'h00;
  localparam logic [PTR_W-1:0] ES_STEP    = 8'h01;
  localparam logic [PTR_W-1:0] TABLE_STEP = 8'h02;
  localparam logic [PTR_W-1:0] RS_STEP    = 8'h04;
  localparam logic [PTR_W-1:0] RP_SW_INIT = 8'hfc;
  localparam logic [NIB_W-1:0] TOS_RESET  = 4'h0;

  localparam int FLAG_CARRY  = 0;
  localparam int FLAG_BRANCH = 1;
  localparam int FLAG_RSVD   = 2;
  localparam int FLAG_IE     = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] FLAGS_WMASK = 4'hb;

  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_SEQ     = 4'h1,
    OP_JUMP    = 4'h2,
    OP_CBRANCH = 4'h3,
    OP_CALL    = 4'h4,
    OP_SVCALL  = 4'h5,
    OP_INTR    = 4'h6,
    OP_RET     = 4'h7,
    OP_TABLE   = 4'h8,
    OP_PUSH    = 4'h9,
    OP_POP     = 4'ha,
    OP_ALU     = 4'hb,
    OP_FETCH   = 4'hc,
    OP_STORE   = 4'hd,
    OP_LDPTR   = 4'he,
    OP_FLAG    = 4'hf
  } scr_op_type;

  typedef enum logic [1:0] {SRC_ALU = 2'h0, SRC_PROG = 2'h1, SRC_RAM = 2'h2, SRC_IO = 2'h3} scr_src_type;
  typedef enum logic [1:0] {PTR_SP = 2'h0, PTR_RP = 2'h1, PTR_X = 2'h2, PTR_Y = 2'h3} scr_ptr_type;
  typedef enum logic [1:0] {MODE_PLAIN = 2'h0, MODE_PREINC = 2'h1, MODE_POSTDEC = 2'h2} scr_mode_type;
  typedef enum logic [1:0] {ALU_ARITH = 2'h0, ALU_LOGIC = 2'h1, ALU_SHIFT = 2'h2} scr_alu_class_type;
  typedef enum logic [2:0] {
    FL_PRESET = 3'h0,
    FL_TOGGLE = 3'h1,
    FL_WRITE  = 3'h2,
    FL_MASK   = 3'h3,
    FL_UNMASK = 3'h4,
    FL_SLEEP  = 3'h5
  } scr_flag_fn_type;

  typedef struct packed {
    scr_op_type       op;
    logic             step;
    scr_src_type      src;
    scr_ptr_type      ptr;
    scr_mode_type     mode;
    logic             consume;
    scr_flag_fn_type  flag_fn;
    logic [FC_W-1:0]  target;
    logic [PTR_W-1:0] data;
  } scr_cmd_type;

  typedef struct packed {
    logic [NIB_W-1:0]  result;
    logic              carry;
    logic              branch;
    scr_alu_class_type klass;
  } scr_alu_type;

  typedef struct packed {
    logic [PTR_W-1:0] sp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W-1:0] x;
    logic [PTR_W-1:0] y;
  } scr_ptrs_type;
endpackage

// ===== hdl/scr_mcycle.sv
`timescale 1ns/1ns
`default_nettype none
module scr_mcycle
  import scr_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  output logic      exec_o
);
  typedef enum logic [1:0] {PH_FETCH = 2'h1, PH_EXEC = 2'h2} scr_phase_type;

  scr_phase_type phase_reg;
  scr_phase_type phase_next;

  // Two phases make one machine cycle of MCYCLE_CLKS clocks.
  always_comb begin
    unique case (phase_reg)
      PH_FETCH: phase_next = PH_EXEC;
      PH_EXEC:  phase_next = PH_FETCH;
      default:  phase_next = PH_FETCH;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_reg <= PH_FETCH;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign exec_o = (phase_reg == PH_EXEC);
endmodule
`default_nettype wire

// ===== hdl/scr_core_regs.sv
`timescale 1ns/1ns
`default_nettype none
module scr_core_regs
  import scr_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             cmd_valid_i,
  input  wire scr_cmd_type      cmd_i,
  output logic                  cmd_ready_o,
  input  wire scr_alu_type      alu_i,
  input  wire logic [7:0]       prog_data_i,
  input  wire logic [NIB_W-1:0] io_data_i,
  output logic [FC_W-1:0]       fetch_counter_o,
  output logic [NIB_W-1:0]      stack_top_o,
  output logic [NIB_W-1:0]      stack_second_o,
  output logic [3:0]            flags_o,
  output scr_ptrs_type          ptrs_o,
  output logic                  irq_ack_o,
  output logic                  sleep_o,
  output logic                  sys_tick_o
);
  logic [NIB_W-1:0] ram [0:RAM_WORDS-1];

  logic             exec_phase;
  logic             busy_reg;
  scr_cmd_type      cmd_reg;
  logic             commit;

  logic [FC_W-1:0]  fetch_counter_reg;
  logic [FC_W-1:0]  fetch_counter_next;
  logic [PTR_W-1:0] expr_stack_pointer_reg;
  logic [PTR_W-1:0] expr_stack_pointer_next;
  logic [PTR_W-1:0] return_stack_pointer_reg;
  logic [PTR_W-1:0] return_stack_pointer_next;
  logic [PTR_W-1:0] x_ptr_reg;
  logic [PTR_W-1:0] x_ptr_next;
  logic [PTR_W-1:0] y_ptr_reg;
  logic [PTR_W-1:0] y_ptr_next;
  logic [NIB_W-1:0] stack_top_reg;
  logic [NIB_W-1:0] stack_top_next;
  logic [3:0]       flag_register_reg;
  logic [3:0]       flag_register_next;
  logic             irq_ack_reg;
  logic             sleep_reg;

  logic [2:0]       wr_en;
  logic [PTR_W-1:0] wr_base;
  logic [FC_W-1:0]  wr_data;

  logic [FC_W-1:0]  fc_seq;
  logic [FC_W-1:0]  vec_target;
  logic [FC_W-1:0]  call_target;
  logic [FC_W-1:0]  ret_addr;
  logic             call_go;
  logic [PTR_W-1:0] sp_inc;
  logic [PTR_W-1:0] sp_dec;
  logic [PTR_W-1:0] rp_push;
  logic [PTR_W-1:0] rp_pop;
  logic [PTR_W-1:0] rp_p1;
  logic [PTR_W-1:0] rp_p2;
  logic [PTR_W-1:0] gp_ptr;
  logic [PTR_W-1:0] gp_eff;
  logic [PTR_W-1:0] gp_new;
  logic             gp_is_y;
  logic [NIB_W-1:0] stack_second_item;
  logic [NIB_W-1:0] src_nib;
  logic             sleep_evt;
  logic             intr_evt;

  scr_mcycle u_mcycle (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .exec_o    (exec_phase)
  );

  // Commands are taken in the first half of a machine cycle and committed in the second.
  assign cmd_ready_o = ~exec_phase;
  assign commit      = exec_phase & busy_reg;
  assign sys_tick_o  = exec_phase;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_reg <= 1'b0;
      cmd_reg  <= '0;
    end else if (!exec_phase) begin
      busy_reg <= cmd_valid_i;
      cmd_reg  <= cmd_i;
    end
  end

  // Pointer arithmetic wraps within the 256-nibble space.
  assign sp_inc  = expr_stack_pointer_reg + ES_STEP;
  assign sp_dec  = expr_stack_pointer_reg - ES_STEP;
  assign rp_push = return_stack_pointer_reg + RS_STEP;
  assign rp_pop  = return_stack_pointer_reg - RS_STEP;
  assign rp_p1   = return_stack_pointer_reg + ES_STEP;
  assign rp_p2   = rp_p1 + ES_STEP;

  assign stack_second_item = ram[expr_stack_pointer_reg];
  assign ret_addr = {ram[rp_p2], ram[rp_p1], ram[return_stack_pointer_reg]};

  assign gp_is_y = (cmd_reg.ptr == PTR_Y);
  assign gp_ptr  = gp_is_y ? y_ptr_reg : x_ptr_reg;
  assign gp_eff  = (cmd_reg.mode == MODE_PREINC) ? gp_ptr + ES_STEP : gp_ptr;
  assign gp_new  = (cmd_reg.mode == MODE_PREINC)  ? gp_ptr + ES_STEP :
                   (cmd_reg.mode == MODE_POSTDEC) ? gp_ptr - ES_STEP : gp_ptr;

  assign fc_seq      = fetch_counter_reg + FC_STEP;
  assign vec_target  = {{(FC_W-ZP_W){1'b0}}, cmd_reg.target[ZP_W-1:0]};
  assign call_target = (cmd_reg.op == OP_CALL) ? cmd_reg.target : vec_target;
  // An interrupt acknowledge that arrives while enable is clear is dropped here.
  assign call_go     = (cmd_reg.op != OP_INTR) | flag_register_reg[FLAG_IE];

  assign src_nib = (cmd_reg.src == SRC_ALU)  ? alu_i.result :
                   (cmd_reg.src == SRC_PROG) ? prog_data_i[NIB_W-1:0] :
                   (cmd_reg.src == SRC_RAM)  ? ram[gp_eff] : io_data_i;

  assign intr_evt  = commit & (cmd_reg.op == OP_INTR) & flag_register_reg[FLAG_IE];
  assign sleep_evt = commit & (cmd_reg.op == OP_FLAG) & (cmd_reg.flag_fn == FL_SLEEP);

  always_comb begin
    fetch_counter_next        = fetch_counter_reg;
    expr_stack_pointer_next   = expr_stack_pointer_reg;
    return_stack_pointer_next = return_stack_pointer_reg;
    x_ptr_next                = x_ptr_reg;
    y_ptr_next                = y_ptr_reg;
    stack_top_next            = stack_top_reg;
    flag_register_next        = flag_register_reg;
    wr_en                     = 3'h0;
    wr_base                   = sp_inc;
    wr_data                   = {8'h00, stack_top_reg};
    if (commit) begin
      if (cmd_reg.step) begin
        fetch_counter_next = fc_seq;
      end
      unique case (cmd_reg.op)
        OP_NOP: begin
        end
        OP_SEQ: begin
          fetch_counter_next = fc_seq;
        end
        OP_JUMP: begin
          fetch_counter_next = cmd_reg.target;
        end
        OP_CBRANCH: begin
          fetch_counter_next = flag_register_reg[FLAG_BRANCH] ? cmd_reg.target : fc_seq;
        end
        OP_CALL, OP_SVCALL, OP_INTR: begin
          fetch_counter_next = fetch_counter_reg;
          if (call_go) begin
            // Three nibbles go above the old top; the fourth slot stays untouched.
            wr_en                     = 3'h7;
            wr_base                   = rp_push;
            wr_data                   = fetch_counter_reg;
            return_stack_pointer_next = rp_push;
            fetch_counter_next        = call_target;
          end
        end
        OP_RET: begin
          fetch_counter_next        = ret_addr;
          return_stack_pointer_next = rp_pop;
        end
        OP_TABLE: begin
          // The high nibble lands as second item and the low nibble as stack top.
          wr_en                   = 3'h3;
          wr_data                 = {4'h0, prog_data_i[7:4], stack_top_reg};
          expr_stack_pointer_next = expr_stack_pointer_reg + TABLE_STEP;
          stack_top_next          = prog_data_i[NIB_W-1:0];
        end
        OP_PUSH: begin
          wr_en                   = 3'h1;
          expr_stack_pointer_next = sp_inc;
          stack_top_next          = src_nib;
        end
        OP_POP: begin
          stack_top_next          = stack_second_item;
          expr_stack_pointer_next = sp_dec;
        end
        OP_ALU: begin
          stack_top_next = alu_i.result;
          if (cmd_reg.consume) begin
            expr_stack_pointer_next = sp_dec;
          end
          flag_register_next[FLAG_BRANCH] = alu_i.branch;
          if (alu_i.klass != ALU_LOGIC) begin
            flag_register_next[FLAG_CARRY] = alu_i.carry;
          end
        end
        OP_FETCH: begin
          wr_en                   = 3'h1;
          expr_stack_pointer_next = sp_inc;
          stack_top_next          = ram[gp_eff];
          if (gp_is_y) begin
            y_ptr_next = gp_new;
          end else begin
            x_ptr_next = gp_new;
          end
        end
        OP_STORE: begin
          wr_en                   = 3'h1;
          wr_base                 = gp_eff;
          stack_top_next          = stack_second_item;
          expr_stack_pointer_next = sp_dec;
          if (gp_is_y) begin
            y_ptr_next = gp_new;
          end else begin
            x_ptr_next = gp_new;
          end
        end
        OP_LDPTR: begin
          unique case (cmd_reg.ptr)
            PTR_SP: expr_stack_pointer_next   = cmd_reg.data;
            PTR_RP: return_stack_pointer_next = cmd_reg.data;
            PTR_X:  x_ptr_next                = cmd_reg.data;
            PTR_Y:  y_ptr_next                = cmd_reg.data;
          endcase
        end
        OP_FLAG: begin
          unique case (cmd_reg.flag_fn)
            FL_PRESET: begin
              flag_register_next[FLAG_CARRY]  = 1'b1;
              flag_register_next[FLAG_BRANCH] = 1'b1;
            end
            FL_TOGGLE: flag_register_next[FLAG_BRANCH] = ~flag_register_reg[FLAG_BRANCH];
            FL_WRITE: begin
              // A flag write may drop the enable but never raise it; only unmask and sleep do that.
              flag_register_next          = stack_top_reg & FLAGS_WMASK;
              flag_register_next[FLAG_IE] = flag_register_reg[FLAG_IE] & stack_top_reg[FLAG_IE];
            end
            FL_MASK:   flag_register_next[FLAG_IE] = 1'b0;
            FL_UNMASK: flag_register_next[FLAG_IE] = 1'b1;
            FL_SLEEP:  flag_register_next[FLAG_IE] = 1'b1;
            default: begin
            end
          endcase
        end
      endcase
    end
    flag_register_next[FLAG_RSVD] = 1'b0;
  end

  // The array carries no reset; its contents are data, not control state.
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < RS_NIBS; i++) begin
      if (wr_en[i]) begin
        ram[wr_base + PTR_W'(i)] <= wr_data[NIB_W*i +: NIB_W];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_counter_reg        <= FC_RESET;
      expr_stack_pointer_reg   <= PTR_RESET;
      return_stack_pointer_reg <= PTR_RESET;
      x_ptr_reg                <= PTR_RESET;
      y_ptr_reg                <= PTR_RESET;
      stack_top_reg            <= TOS_RESET;
      flag_register_reg        <= FLAGS_RESET;
      irq_ack_reg              <= 1'b0;
      sleep_reg                <= 1'b0;
    end else begin
      fetch_counter_reg        <= fetch_counter_next;
      expr_stack_pointer_reg   <= expr_stack_pointer_next;
      return_stack_pointer_reg <= return_stack_pointer_next;
      x_ptr_reg                <= x_ptr_next;
      y_ptr_reg                <= y_ptr_next;
      stack_top_reg            <= stack_top_next;
      flag_register_reg        <= flag_register_next;
      irq_ack_reg              <= intr_evt;
      sleep_reg                <= sleep_evt;
    end
  end

  assign fetch_counter_o = fetch_counter_reg;
  assign stack_top_o     = stack_top_reg;
  assign stack_second_o  = stack_second_item;
  assign flags_o         = flag_register_reg;
  assign ptrs_o          = '{sp: expr_stack_pointer_reg, rp: return_stack_pointer_reg, x: x_ptr_reg, y: y_ptr_reg};
  assign irq_ack_o       = irq_ack_reg;
  assign sleep_o         = sleep_reg;

  default clocking scr_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  chk_mcycle_phase: assert property (
    cmd_ready_o |=> !cmd_ready_o ##1 cmd_ready_o)
    else $error("machine cycle is not two clocks");

  chk_fc_step: assert property (
    commit && cmd_reg.op == OP_SEQ |=> fetch_counter_o == $past(fetch_counter_o) + FC_STEP)
    else $error("fetch counter did not step");

  chk_jump_load: assert property (
    commit && cmd_reg.op == OP_JUMP |=> fetch_counter_o == $past(cmd_reg.target))
    else $error("jump target not loaded");

  chk_vector_zero_page: assert property (
    commit && cmd_reg.op == OP_SVCALL |=> fetch_counter_o < ZP_LIMIT && ptrs_o.rp == $past(ptrs_o.rp) + RS_STEP)
    else $error("short call left the zero page or bad return step");

  chk_call_return: assert property (
    (commit && cmd_reg.op == OP_CALL) ##2 (commit && cmd_reg.op == OP_RET)
    |=> fetch_counter_o == $past(fetch_counter_o, 3) && ptrs_o.rp == $past(ptrs_o.rp, 3))
    else $error("return did not restore call site");

  chk_pop_order: assert property (
    commit && cmd_reg.op == OP_POP |=> stack_top_o == $past(stack_second_o) && ptrs_o.sp == $past(ptrs_o.sp) - ES_STEP)
    else $error("pop order broken");

  chk_push_order: assert property (
    commit && cmd_reg.op == OP_PUSH |=> ptrs_o.sp == $past(ptrs_o.sp) + ES_STEP && stack_second_o == $past(stack_top_o))
    else $error("push did not pre-increment");

  chk_logic_carry: assert property (
    commit && cmd_reg.op == OP_ALU && alu_i.klass == ALU_LOGIC
    |=> $stable(flags_o[FLAG_CARRY]) && flags_o[FLAG_BRANCH] == $past(alu_i.branch))
    else $error("logic op changed carry");

  chk_arith_carry: assert property (
    commit && cmd_reg.op == OP_ALU && alu_i.klass != ALU_LOGIC |=> flags_o[FLAG_CARRY] == $past(alu_i.carry))
    else $error("carry not recorded");

  chk_cbranch_fall: assert property (
    commit && cmd_reg.op == OP_CBRANCH && !flags_o[FLAG_BRANCH] |=> fetch_counter_o == $past(fetch_counter_o) + FC_STEP)
    else $error("branch taken with flag clear");

  chk_ie_mask: assert property (
    commit && cmd_reg.op == OP_FLAG && cmd_reg.flag_fn == FL_MASK |=> !flags_o[FLAG_IE])
    else $error("mask left enable set");

  chk_intr_gate: assert property (
    commit && cmd_reg.op == OP_INTR && !flags_o[FLAG_IE] |=> $stable(fetch_counter_o) && !irq_ack_o)
    else $error("interrupt started while masked");

  chk_ie_raise: assert property (
    $rose(flags_o[FLAG_IE]) |-> $past(commit && cmd_reg.op == OP_FLAG &&
                                     (cmd_reg.flag_fn == FL_UNMASK || cmd_reg.flag_fn == FL_SLEEP)))
    else $error("enable set by wrong source");

  chk_store_postdec: assert property (
    commit && cmd_reg.op == OP_STORE && cmd_reg.ptr == PTR_X && cmd_reg.mode == MODE_POSTDEC
    |=> ptrs_o.x == $past(ptrs_o.x) - ES_STEP)
    else $error("store post-decrement wrong");

  chk_rsvd_zero: assert property (
    flags_o[FLAG_RSVD] == 1'b0)
    else $error("spare flag bit set");

  cov_call_return: cover property ((commit && cmd_reg.op == OP_CALL) ##2 (commit && cmd_reg.op == OP_RET));
  cov_intr_taken: cover property (irq_ack_o);
  cov_table_read: cover property (commit && cmd_reg.op == OP_TABLE);
  cov_branch_taken: cover property (commit && cmd_reg.op == OP_CBRANCH && flags_o[FLAG_BRANCH]);
endmodule
`default_nettype wire

// ===== verif/scr_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module scr_prog_model
  import scr_pkg::*;
(
  input  wire logic [FC_W-1:0] addr_i,
  output logic [7:0]           data_o
);
  // A pattern of the low address byte keeps table reads distinct within each 256-byte block.
  assign data_o = addr_i[7:0] ^ 8'h5a;
endmodule
`default_nettype wire

// ===== verif/scr_core_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module scr_core_regs_tb_top;
  import scr_pkg::*;
  logic             sys_clk_i = 1'b0;
  logic             reset_i = 1'b1;
  logic             cmd_valid_i = 1'b0;
  scr_cmd_type      cmd_i;
  scr_alu_type      alu_i;
  logic [7:0]       prog_data_i;
  logic [NIB_W-1:0] io_data_i;
  logic             cmd_ready_o;
  logic [FC_W-1:0]  fetch_counter_o;
  logic [NIB_W-1:0] stack_top_o;
  logic [NIB_W-1:0] stack_second_o;
  logic [3:0]       flags_o;
  scr_ptrs_type     ptrs_o;
  logic             irq_ack_o;
  logic             sleep_o;
  logic             sys_tick_o;
  int               fails = 0;
  int               total_checks = 0;

  always #(CLK_PERIOD_NS/2) sys_clk_i = ~sys_clk_i;

  scr_core_regs dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .alu_i(alu_i), .prog_data_i(prog_data_i), .io_data_i(io_data_i),
    .fetch_counter_o(fetch_counter_o), .stack_top_o(stack_top_o), .stack_second_o(stack_second_o),
    .flags_o(flags_o), .ptrs_o(ptrs_o), .irq_ack_o(irq_ack_o), .sleep_o(sleep_o), .sys_tick_o(sys_tick_o));

  scr_prog_model prog (.addr_i(fetch_counter_o), .data_o(prog_data_i));

  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic c4(input logic [3:0] g, input logic [3:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t nibble got %h exp %h", $time, g, e);
    end
  endtask

  task automatic c8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t pointer got %h exp %h", $time, g, e);
    end
  endtask

  task automatic c12(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t counter got %h exp %h", $time, g, e);
    end
  endtask

  function automatic scr_cmd_type mk(input scr_op_type op, input logic [11:0] t);
    scr_cmd_type c;
    c = '0;
    c.op = op;
    c.target = t;
    return c;
  endfunction

  // Waits for a fetch clock, presents the command for one clock and returns after commit.
  task automatic run(input scr_cmd_type c, input logic [3:0] io);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 8) begin
      fails++;
      $display("CHECK FAILED t=%0t no fetch phase", $time);
      report_and_stop();
    end
    cmd_i = c;
    io_data_i = io;
    cmd_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    c4({2'h0, cmd_ready_o, sys_tick_o}, 4'h1);
    cmd_valid_i = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic ld(input scr_ptr_type p, input logic [7:0] d);
    scr_cmd_type c;
    c = mk(OP_LDPTR, 12'h000);
    c.ptr = p;
    c.data = d;
    run(c, 4'h0);
  endtask

  task automatic fl(input scr_flag_fn_type f, input logic [3:0] e);
    scr_cmd_type c;
    c = mk(OP_FLAG, 12'h000);
    c.flag_fn = f;
    run(c, 4'h0);
    c4(flags_o, e);
  endtask

  task automatic push_io(input logic [3:0] v);
    scr_cmd_type c;
    c = mk(OP_PUSH, 12'h000);
    c.src = SRC_IO;
    run(c, v);
  endtask

  task automatic alu(input logic [3:0] r, input logic cy, input logic br, input scr_alu_class_type k);
    alu_i = '{result: r, carry: cy, branch: br, klass: k};
    run(mk(OP_ALU, 12'h000), 4'h0);
  endtask

  task automatic t_reset();
    c12(fetch_counter_o, FC_RESET);
    c4(flags_o, 4'h0);
    c8(ptrs_o.rp, 8'h00);
    c4(stack_top_o, 4'h0);
  endtask

  task automatic t_flow();
    ld(PTR_RP, 8'hfc);
    ld(PTR_SP, 8'h10);
    c8(ptrs_o.rp, 8'hfc);
    run(mk(OP_SEQ, 12'h000), 4'h0);
    c12(fetch_counter_o, 12'h001);
    run(mk(OP_JUMP, 12'h3a7), 4'h0);
    c12(fetch_counter_o, 12'h3a7);
  endtask

  task automatic t_stack();
    push_io(4'ha);
    push_io(4'h3);
    c4(stack_top_o, 4'h3);
    c4(stack_second_o, 4'ha);
    c8(ptrs_o.sp, 8'h12);
    run(mk(OP_POP, 12'h000), 4'h0);
    c4(stack_top_o, 4'ha);
    c8(ptrs_o.sp, 8'h11);
    run(mk(OP_TABLE, 12'h000), 4'h0);
    c4(stack_top_o, 4'hd);
    c4(stack_second_o, 4'hf);
    c8(ptrs_o.sp, 8'h13);
  endtask

  task automatic t_call();
    run(mk(OP_CALL, 12'h345), 4'h0);
    c12(fetch_counter_o, 12'h345);
    c8(ptrs_o.rp, 8'h00);
    run(mk(OP_RET, 12'h000), 4'h0);
    c12(fetch_counter_o, 12'h3a7);
    c8(ptrs_o.rp, 8'hfc);
    run(mk(OP_SVCALL, 12'hfc0), 4'h0);
    c12(fetch_counter_o, 12'h1c0);
    c8(ptrs_o.rp, 8'h00);
    run(mk(OP_RET, 12'h000), 4'h0);
    c12(fetch_counter_o, 12'h3a7);
  endtask

  task automatic t_flags();
    fl(FL_PRESET, 4'h3);
    fl(FL_TOGGLE, 4'h1);
    fl(FL_UNMASK, 4'h9);
    run(mk(OP_INTR, 12'hfff), 4'h0);
    c12(fetch_counter_o, 12'h1ff);
    c4({3'h0, irq_ack_o}, 4'h1);
    fl(FL_MASK, 4'h1);
    run(mk(OP_INTR, 12'h0c0), 4'h0);
    c12(fetch_counter_o, 12'h1ff);
    c4({3'h0, irq_ack_o}, 4'h0);
    fl(FL_SLEEP, 4'h9);
    c4({3'h0, sleep_o}, 4'h1);
    fl(FL_MASK, 4'h1);
    push_io(4'hf);
    fl(FL_WRITE, 4'h3);
  endtask

  task automatic t_alu();
    alu(4'h5, 1'b0, 1'b0, ALU_LOGIC);
    c4(stack_top_o, 4'h5);
    c4(flags_o, 4'h1);
    run(mk(OP_CBRANCH, 12'h0aa), 4'h0);
    c12(fetch_counter_o, 12'h200);
    alu(4'h2, 1'b0, 1'b1, ALU_ARITH);
    c4(flags_o, 4'h2);
    run(mk(OP_CBRANCH, 12'h0aa), 4'h0);
    c12(fetch_counter_o, 12'h0aa);
    alu(4'h7, 1'b1, 1'b0, ALU_SHIFT);
    c4(flags_o, 4'h1);
  endtask

  task automatic t_ram();
    scr_cmd_type c;
    ld(PTR_X, 8'h40);
    c = mk(OP_STORE, 12'h000);
    c.ptr = PTR_X;
    c.mode = MODE_PREINC;
    run(c, 4'h0);
    c8(ptrs_o.x, 8'h41);
    c.op = OP_FETCH;
    c.mode = MODE_POSTDEC;
    run(c, 4'h0);
    c4(stack_top_o, 4'h7);
    c8(ptrs_o.x, 8'h40);
    c.op = OP_STORE;
    run(c, 4'h0);
    c8(ptrs_o.x, 8'h3f);
    c4(stack_top_o, 4'hd);
    ld(PTR_Y, 8'h40);
    c.op = OP_FETCH;
    c.ptr = PTR_Y;
    c.mode = MODE_PLAIN;
    run(c, 4'h0);
    c4(stack_top_o, 4'h7);
    c8(ptrs_o.y, 8'h40);
    c.op = OP_PUSH;
    c.src = SRC_PROG;
    c.step = 1'b1;
    run(c, 4'h5);
    c4(stack_top_o, 4'h0);
    c12(fetch_counter_o, 12'h0ab);
    c = mk(OP_ALU, 12'h000);
    c.consume = 1'b1;
    alu_i = '{result: 4'h6, carry: 1'b0, branch: 1'b0, klass: ALU_ARITH};
    run(c, 4'h0);
    c4(stack_top_o, 4'h6);
    c8(ptrs_o.sp, 8'h14);
  endtask

  initial begin
    cmd_i = '0;
    alu_i = '0;
    io_data_i = 4'h0;
    repeat (12) @(posedge sys_clk_i);
    #1;
    t_reset();
    reset_i = 1'b0;
    t_flow();
    t_stack();
    t_call();
    t_flags();
    t_alu();
    t_ram();
    report_and_stop();
  end
endmodule
`default_nettype wire
